// ===== hdl/flash_sector_host.sv
`timescale 1ns/1ps
`default_nettype none
module flash_sector_host #(
    parameter int          BLC_CYCLES  = flash_host_pkg::BLC_CYC,  // Longest gap between loads.
    parameter int          POLL_LIMIT  = flash_host_pkg::POLL_CYC, // Polling give-up count.
    parameter logic [14:0] SEQ_ADDR_1  = flash_host_pkg::DEF_SEQ_ADDR_1,
    parameter logic [14:0] SEQ_ADDR_2  = flash_host_pkg::DEF_SEQ_ADDR_2,
    parameter logic [7:0]  SEQ_DATA_1  = flash_host_pkg::DEF_SEQ_DATA_1,
    parameter logic [7:0]  SEQ_DATA_2  = flash_host_pkg::DEF_SEQ_DATA_2,
    parameter logic [7:0]  CMD_PROT    = flash_host_pkg::DEF_CMD_PROT,
    parameter logic [7:0]  CMD_UNPROT  = flash_host_pkg::DEF_CMD_UNPROT,
    parameter logic [7:0]  CMD_ID_IN   = flash_host_pkg::DEF_CMD_ID_IN,
    parameter logic [7:0]  CMD_ID_OUT  = flash_host_pkg::DEF_CMD_ID_OUT,
    parameter logic [7:0]  CMD_LOCK_L  = flash_host_pkg::DEF_CMD_LOCK_L,
    parameter logic [7:0]  CMD_LOCK_H  = flash_host_pkg::DEF_CMD_LOCK_H
) (
    input  wire logic        I_SYS_CLK,
    input  wire logic        I_RESET,
    input  wire logic        i_CMD_VALID,
    input  wire logic [2:0]  i_CMD_OP,
    input  wire logic [18:0] i_CMD_ADDR,
    input  wire logic        i_WR_VALID,
    input  wire logic [7:0]  i_WR_DATA,
    output logic             o_WR_ACK,
    output logic             o_BUSY,
    output logic             o_DONE,
    output logic             o_ERR,
    output logic [7:0]       o_RD_DATA,
    output logic             o_ID_MODE,
    output logic [18:0]      o_FLASH_ADDR,
    output logic             o_FLASH_CE_N,
    output logic             o_FLASH_OE_N,
    output logic             o_FLASH_WE_N,
    input  wire logic [7:0]  i_FLASH_DQ,
    output logic [7:0]       o_FLASH_DQ,
    output logic             o_FLASH_DQ_OE
);
    typedef enum logic [2:0] {S_IDLE, S_SEQ, S_LOAD, S_WR_LOW, S_WR_HIGH, S_RD_LOW, S_RD_HIGH, S_DONE} state_e;

    state_e              state_q, state_d;   // Controller state.
    flash_host_pkg::op_e op_q;               // Operation in progress.
    logic [10:0]         sector_q;           // Target sector, held for the whole operation.
    logic [1:0]          seq_idx_q;          // Command write index.
    logic                seq_wr_q;           // Current write belongs to a command sequence.
    logic [7:0]          byte_q;             // Next byte offset to load.
    logic [8:0]          loads_q;            // Byte loads issued in this sector.
    logic [7:0]          timer_q;            // Phase down-counter.
    logic [23:0]         gap_q;              // Cycles since the last load strobe fell.
    logic [23:0]         wait_q;             // Cycles spent polling.
    logic                polling_q;          // Reads are toggle polls, not data reads.
    logic                have_prev_q;        // A previous poll sample exists.
    logic                prev_bit_q;         // Toggle bit of the previous poll.
    logic                same_q;             // Last two polls showed no toggle.
    logic [7:0]          dq_sync;            // Synchronised data lines.
    logic [14:0]         seq_addr;           // Address of the current command write.
    logic [7:0]          seq_data;           // Data of the current command write.
    logic                phase_end;          // Current phase has run its time.
    logic                gap_over;           // Next load would break the byte load timeout.
    logic                poll_op;            // Operation ends with a program cycle.
    flash_host_pkg::op_e cmd_op;             // Requested operation.

    assign cmd_op    = flash_host_pkg::op_e'(i_CMD_OP);
    assign phase_end = (timer_q == 8'h00);
    assign gap_over  = (gap_q >= 24'(BLC_CYCLES - 1));
    assign poll_op   = !(op_q inside {flash_host_pkg::OP_ID_ENTER, flash_host_pkg::OP_ID_EXIT});

    // Pin data pass the synchroniser before any decision looks at them.
    flash_pin_sync #(.W(flash_host_pkg::DATA_W)) u_dq_sync (
        .i_clk   (I_SYS_CLK),
        .i_reset (I_RESET),
        .i_d     (i_FLASH_DQ),
        .o_q     (dq_sync)
    );

    // Command sequence words; every byte is a parameter so that any unlock code can be used.
    always_comb begin
        seq_addr = (seq_idx_q == 2'h1) ? SEQ_ADDR_2 : SEQ_ADDR_1;
        seq_data = SEQ_DATA_1;
        if (seq_idx_q == 2'h1) begin
            seq_data = SEQ_DATA_2;
        end else if (seq_idx_q == flash_host_pkg::SEQ_LAST) begin
            unique case (op_q)
                flash_host_pkg::OP_PROG_PROTECT:   seq_data = CMD_PROT;
                flash_host_pkg::OP_PROG_UNPROTECT: seq_data = CMD_UNPROT;
                flash_host_pkg::OP_ID_ENTER:       seq_data = CMD_ID_IN;
                flash_host_pkg::OP_ID_EXIT:        seq_data = CMD_ID_OUT;
                flash_host_pkg::OP_LOCK_LOW:       seq_data = CMD_LOCK_L;
                flash_host_pkg::OP_LOCK_HIGH:      seq_data = CMD_LOCK_H;
                default:                           seq_data = SEQ_DATA_1;
            endcase
        end
    end

    // Next state; phases end when their timer runs out.
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            S_IDLE: begin
                if (i_CMD_VALID) begin
                    if (cmd_op == flash_host_pkg::OP_READ) begin
                        state_d = S_RD_LOW;
                    end else if (cmd_op == flash_host_pkg::OP_PROG) begin
                        state_d = S_LOAD;
                    end else begin
                        state_d = S_SEQ;
                    end
                end
            end
            S_SEQ: state_d = S_WR_LOW;
            S_LOAD: begin
                // A late byte cannot be rescued: the device has already started programming.
                if (gap_over) begin
                    state_d = S_RD_LOW;
                end else if (i_WR_VALID) begin
                    state_d = S_WR_LOW;
                end
            end
            S_WR_LOW: if (phase_end) state_d = S_WR_HIGH;
            S_WR_HIGH: begin
                if (phase_end) begin
                    if (seq_wr_q && seq_idx_q != flash_host_pkg::SEQ_LAST) begin
                        state_d = S_SEQ;
                    end else if (seq_wr_q) begin
                        if (op_q inside {flash_host_pkg::OP_PROG_PROTECT, flash_host_pkg::OP_PROG_UNPROTECT}) begin
                            state_d = S_LOAD;
                        end else begin
                            state_d = poll_op ? S_RD_LOW : S_DONE;
                        end
                    end else begin
                        state_d = (byte_q == flash_host_pkg::LAST_BYTE) ? S_RD_LOW : S_LOAD;
                    end
                end
            end
            S_RD_LOW: if (phase_end) state_d = S_RD_HIGH;
            S_RD_HIGH: begin
                if (phase_end) begin
                    // Only a stopped toggle or the give-up count ends polling.
                    if (!polling_q || same_q || wait_q >= 24'(POLL_LIMIT)) begin
                        state_d = S_DONE;
                    end else begin
                        state_d = S_RD_LOW;
                    end
                end
            end
            S_DONE: state_d = S_IDLE;
        endcase
    end

    // State, phase timer and operation bookkeeping.
    always_ff @(posedge I_SYS_CLK) begin
        if (I_RESET) begin
            state_q   <= S_IDLE;
            op_q      <= flash_host_pkg::OP_READ;
            sector_q  <= '0;
            seq_idx_q <= '0;
            seq_wr_q  <= 1'b0;
            byte_q    <= '0;
            loads_q   <= '0;
            timer_q   <= '0;
        end else begin
            state_q <= state_d;
            if (state_d != state_q) begin
                unique case (state_d)
                    S_WR_LOW:  timer_q <= flash_host_pkg::TWP_CYC - 8'h01;
                    S_WR_HIGH: timer_q <= flash_host_pkg::TWPH_CYC - 8'h01;
                    S_RD_LOW:  timer_q <= flash_host_pkg::TRD_CYC - 8'h01;
                    S_RD_HIGH: timer_q <= flash_host_pkg::TOEHP_CYC - 8'h01;
                    default:   timer_q <= 8'h00;
                endcase
            end else if (!phase_end) begin
                timer_q <= timer_q - 8'h01;
            end
            if (state_q == S_IDLE && i_CMD_VALID) begin
                op_q      <= cmd_op;
                sector_q  <= i_CMD_ADDR[18:8];
                seq_idx_q <= '0;
                byte_q    <= '0;
                loads_q   <= '0;
            end
            if (state_q == S_SEQ) begin
                seq_wr_q <= 1'b1;
            end else if (state_q == S_LOAD) begin
                seq_wr_q <= 1'b0;
            end
            if (state_q == S_WR_HIGH && phase_end) begin
                if (seq_wr_q) begin
                    seq_idx_q <= seq_idx_q + 2'h1;
                end else begin
                    byte_q <= byte_q + 8'h01;
                end
            end
            if (state_q == S_LOAD && state_d == S_WR_LOW) begin
                loads_q <= loads_q + 9'h001;
            end
        end
    end

    // Load spacing and polling time counters.
    always_ff @(posedge I_SYS_CLK) begin
        if (I_RESET || state_q == S_IDLE) begin
            gap_q  <= '0;
            wait_q <= '0;
        end else begin
            gap_q  <= (state_q == S_LOAD && state_d == S_WR_LOW) ? 24'h000000 : gap_q + 24'h000001;
            wait_q <= polling_q ? wait_q + 24'h000001 : 24'h000000;
        end
    end

    // Toggle-bit tracking; a level alone never means completion.
    always_ff @(posedge I_SYS_CLK) begin
        if (I_RESET || state_q == S_IDLE) begin
            polling_q   <= 1'b0;
            have_prev_q <= 1'b0;
            prev_bit_q  <= 1'b0;
            same_q      <= 1'b0;
        end else begin
            // Only an entry from loading or a command write opens a poll; a plain read enters from idle.
            if (state_d == S_RD_LOW && state_q inside {S_LOAD, S_WR_HIGH}) begin
                polling_q <= 1'b1;
            end
            if (polling_q && state_q == S_RD_LOW && phase_end) begin
                same_q      <= have_prev_q && (dq_sync[flash_host_pkg::TOGGLE_BIT] == prev_bit_q);
                prev_bit_q  <= dq_sync[flash_host_pkg::TOGGLE_BIT];
                have_prev_q <= 1'b1;
            end
        end
    end

    // Flash pins, registered from the next state; output enable stays high during writes.
    always_ff @(posedge I_SYS_CLK) begin
        if (I_RESET) begin
            o_FLASH_ADDR  <= '0;
            o_FLASH_CE_N  <= flash_host_pkg::STROBE_IDLE;
            o_FLASH_OE_N  <= flash_host_pkg::STROBE_IDLE;
            o_FLASH_WE_N  <= flash_host_pkg::STROBE_IDLE;
            o_FLASH_DQ    <= '0;
            o_FLASH_DQ_OE <= 1'b0;
        end else begin
            o_FLASH_CE_N  <= !(state_d inside {S_WR_LOW, S_RD_LOW});
            o_FLASH_OE_N  <= (state_d != S_RD_LOW);
            o_FLASH_WE_N  <= (state_d != S_WR_LOW);
            o_FLASH_DQ_OE <= (state_d inside {S_WR_LOW, S_WR_HIGH});
            if (state_q == S_IDLE && i_CMD_VALID) begin
                o_FLASH_ADDR <= i_CMD_ADDR;
            end else if (state_q == S_SEQ) begin
                o_FLASH_ADDR <= {4'h0, seq_addr};
                o_FLASH_DQ   <= seq_data;
            end else if (state_q == S_LOAD && state_d == S_WR_LOW) begin
                o_FLASH_ADDR <= {sector_q, byte_q};
                o_FLASH_DQ   <= i_WR_DATA;
            end else if (state_d == S_RD_LOW && state_q inside {S_LOAD, S_WR_HIGH}) begin
                o_FLASH_ADDR <= {sector_q, 8'h00};
            end
        end
    end

    // User-side answers.
    always_ff @(posedge I_SYS_CLK) begin
        if (I_RESET) begin
            o_WR_ACK  <= 1'b0;
            o_BUSY    <= 1'b0;
            o_DONE    <= 1'b0;
            o_ERR     <= 1'b0;
            o_RD_DATA <= '0;
            o_ID_MODE <= 1'b0;
        end else begin
            o_WR_ACK <= (state_q == S_LOAD && state_d == S_WR_LOW);
            o_BUSY   <= (state_d != S_IDLE);
            o_DONE   <= (state_q == S_DONE);
            if (state_q == S_IDLE && i_CMD_VALID) begin
                o_ERR <= 1'b0;
            end else if ((state_q == S_LOAD && gap_over) ||
                         (state_q == S_RD_HIGH && phase_end && polling_q && !same_q && wait_q >= 24'(POLL_LIMIT))) begin
                o_ERR <= 1'b1;
            end
            if (!polling_q && state_q == S_RD_LOW && phase_end) begin
                o_RD_DATA <= dq_sync;
            end
            if (state_q == S_DONE && op_q == flash_host_pkg::OP_ID_ENTER) begin
                o_ID_MODE <= 1'b1;
            end else if (state_q == S_DONE && op_q == flash_host_pkg::OP_ID_EXIT) begin
                o_ID_MODE <= 1'b0;
            end
        end
    end

    // Write strobe low time as a named sequence.
    sequence we_low_window;
        (!o_FLASH_WE_N)[*8] ##1 !o_FLASH_WE_N;
    endsequence

    a_we_pulse_width: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
        $fell(o_FLASH_WE_N) |-> we_low_window) else $error("Write pulse shorter than nine cycles.");
    a_sector_addr_hold: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
        $fell(o_FLASH_WE_N) && !seq_wr_q |-> o_FLASH_ADDR[18:8] == sector_q) else $error("Sector bits moved during a load.");
    a_cmd_addr_range: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
        $fell(o_FLASH_WE_N) && seq_wr_q |-> o_FLASH_ADDR[18:15] == 4'h0) else $error("Command write used high address bits.");
    a_full_sector: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
        state_q == S_WR_HIGH && state_d == S_RD_LOW && !seq_wr_q |-> loads_q == 9'h100) else $error("Sector left partly loaded.");
    a_load_gap_bound: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
        state_q == S_LOAD |-> gap_q < 24'(BLC_CYCLES)) else $error("Byte load spacing exceeded.");
    a_poll_addr_const: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
        polling_q && $fell(o_FLASH_OE_N) && $past(polling_q) |-> $stable(o_FLASH_ADDR)) else $error("Poll address changed.");
    a_toggle_stop_done: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
        state_q == S_DONE && polling_q && !o_ERR |-> same_q ##1 o_DONE) else $error("Polling ended without a stopped toggle.");
    a_oe_high_write: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
        !o_FLASH_WE_N |-> o_FLASH_OE_N && !o_FLASH_CE_N && o_FLASH_DQ_OE) else $error("Output enable low during a write.");
    a_id_exit_mode: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
        state_q == S_DONE && op_q == flash_host_pkg::OP_ID_EXIT |=> !o_ID_MODE && o_DONE) else $error("Identification mode not left.");
    a_done_pulse: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
        o_DONE |-> !o_BUSY ##1 !o_DONE) else $error("Done pulse longer than one cycle.");

endmodule : flash_sector_host
`default_nettype wire

// ===== inc/flash_host_pkg.sv
`default_nettype none
// Shared constants for the sector flash host controller.
package flash_host_pkg;

    // System clock rate in MHz.
    localparam int CLK_MHZ   = 100;
    // Flash timing figures in their own units.
    localparam int TWP_NS    = 90;       // Least write pulse width.
    localparam int TWPH_NS   = 100;      // Least write pulse high time.
    localparam int TACC_NS   = 100;      // Longest address to data delay.
    localparam int TOEHP_NS  = 150;      // Least output-enable high pulse while toggling.
    localparam int BYTE_LOAD_TIMEOUT_US   = 150;      // Longest spacing between two byte loads.
    localparam int TWC_MS    = 10;       // Longest sector program cycle.
    // Extra read wait for the three-stage input synchroniser and its agreement check.
    localparam int SYNC_CYC  = 4;

    // Cycle counts; pulse widths and the access time round up, the load and program timeouts are exact.
    localparam logic [7:0] TWP_CYC   = 8'((TWP_NS * CLK_MHZ + 999) / 1000);
    localparam logic [7:0] TWPH_CYC  = 8'((TWPH_NS * CLK_MHZ + 999) / 1000);
    localparam logic [7:0] TRD_CYC   = 8'((TACC_NS * CLK_MHZ + 999) / 1000 + SYNC_CYC);
    localparam logic [7:0] TOEHP_CYC = 8'((TOEHP_NS * CLK_MHZ + 999) / 1000);
    localparam int         BLC_CYC   = BYTE_LOAD_TIMEOUT_US * CLK_MHZ;
    localparam int         TWC_CYC   = TWC_MS * 1000 * CLK_MHZ;
    // Polling gives up after twice the longest program cycle.
    localparam int         POLL_CYC  = 2 * TWC_CYC;

    // Bus geometry.
    localparam int ADDR_W      = 19;     // Byte address lines.
    localparam int DATA_W      = 8;      // Data lines.
    localparam int SECTOR_LSB  = 8;      // Lowest sector address bit.
    localparam int CMD_ADDR_W  = 15;     // Address bits that command writes use.
    localparam int TOGGLE_BIT  = 6;      // Position of the toggle status bit.
    localparam logic [7:0] LAST_BYTE = 8'hFF; // Last byte offset in a sector.
    localparam logic [1:0] SEQ_LAST  = 2'h2;  // Index of the last command write.

    // Reset values.
    localparam logic STROBE_IDLE = 1'b1; // Strobes are active low and idle high.

    // Neutral default command sequence; every value is arbitrary and meant to be overridden.
    localparam logic [14:0] DEF_SEQ_ADDR_1 = 15'h0001;
    localparam logic [14:0] DEF_SEQ_ADDR_2 = 15'h0002;
    localparam logic [7:0]  DEF_SEQ_DATA_1 = 8'h01;
    localparam logic [7:0]  DEF_SEQ_DATA_2 = 8'h02;
    localparam logic [7:0]  DEF_CMD_PROT   = 8'h10;
    localparam logic [7:0]  DEF_CMD_UNPROT = 8'h11;
    localparam logic [7:0]  DEF_CMD_ID_IN  = 8'h12;
    localparam logic [7:0]  DEF_CMD_ID_OUT = 8'h13;
    localparam logic [7:0]  DEF_CMD_LOCK_L = 8'h14;
    localparam logic [7:0]  DEF_CMD_LOCK_H = 8'h15;

    // User operations.
    typedef enum logic [2:0] {
        OP_READ, OP_PROG, OP_PROG_PROTECT, OP_PROG_UNPROTECT,
        OP_ID_ENTER, OP_ID_EXIT, OP_LOCK_LOW, OP_LOCK_HIGH
    } op_e;

endpackage : flash_host_pkg
`default_nettype wire

// ===== hdl/flash_pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
// Three-stage synchroniser whose output follows only when the last two stages agree.
module flash_pin_sync #(
    parameter int W = 8
) (
    input  wire logic         i_clk,
    input  wire logic         i_reset,
    input  wire logic [W-1:0] i_d,
    output logic      [W-1:0] o_q
);
    logic [W-1:0] s1_q; // First stage, read only by the second.
    logic [W-1:0] s2_q; // Second stage.
    logic [W-1:0] s3_q; // Third stage.

    // Shift the pin through the chain; a change counts once stages two and three agree.
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            o_q  <= '0;
        end else begin
            s1_q <= i_d;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) begin
                o_q <= s3_q;
            end
        end
    end
endmodule : flash_pin_sync
`default_nettype wire

// ===== testbench/flash_part_model.sv
`timescale 1ns/1ps
`default_nettype none
// Behavioural flash part as the host sees it: no clock; writes and status toggles follow strobe edges, programming and the released bus run on delays.
module flash_part_model #(
    parameter logic [7:0] MAN_ID = 8'h3C, // Arbitrary maker code.
    parameter logic [7:0] DEV_ID = 8'h7E  // Arbitrary part code.
) (
    input  wire logic [18:0] i_addr,
    input  wire logic        i_ce_n,
    input  wire logic        i_oe_n,
    input  wire logic        i_we_n,
    input  wire logic [7:0]  i_dq,
    output logic      [7:0]  o_dq
);
    localparam logic [22:0] W1 = {flash_host_pkg::DEF_SEQ_ADDR_1, flash_host_pkg::DEF_SEQ_DATA_1};
    localparam logic [22:0] W2 = {flash_host_pkg::DEF_SEQ_ADDR_2, flash_host_pkg::DEF_SEQ_DATA_2};
    logic [7:0]  mem [0:524287];     // Array contents.
    logic [7:0]  ld [int];           // Bytes loaded into the open sector.
    logic [10:0] sect;               // Sector of the open load.
    logic [18:0] a;                  // Commit address.
    logic [22:0] h0, h1, h2;         // Last three writes, low address and data.
    logic [7:0]  flt = 8'h5A;        // Released bus pattern.
    logic busy = 0, tog = 0, prot = 0, pp = 0, pu = 0, lk_lo = 0, lk_hi = 0, go = 0;
    logic id = 0;                    // Power-up starts in array read mode.
    time  t_last = 0;                // Time of the last write strobe, load or command.
    wire  wr_n = i_ce_n | i_we_n;
    wire  rd_n = i_ce_n | i_oe_n;
    initial for (int i = 0; i < 524288; i++) mem[i] = 8'hFF;
    // A released bus changes every cycle, so no stale value can pass for data.
    always #10 flt = ~flt;
    // Writes are taken as the strobe ends, while address and data still stand.
    always @(posedge wr_n) if ($time > 20) begin
        h0 = h1;
        h1 = h2;
        h2 = {i_addr[14:0], i_dq};
        if (h0 == W1 && h1 == W2 && h2[22:8] == W1[22:8]) begin
            case (h2[7:0])
                flash_host_pkg::DEF_CMD_ID_IN:  id = 1'b1;
                flash_host_pkg::DEF_CMD_ID_OUT: id = 1'b0;
                flash_host_pkg::DEF_CMD_PROT:   pp = 1'b1;
                flash_host_pkg::DEF_CMD_UNPROT: pu = 1'b1;
                flash_host_pkg::DEF_CMD_LOCK_L: begin lk_lo = 1'b1; go = 1'b1; end
                flash_host_pkg::DEF_CMD_LOCK_H: begin lk_hi = 1'b1; go = 1'b1; end
                default: ;
            endcase
            ld.delete();
            h2 = '0;
        end else begin
            sect = i_addr[18:8];
            ld[i_addr[7:0]] = i_dq;
            if (ld.num() == 256) go = 1'b1;
        end
        t_last = $time;
    end
    // A program cycle starts on a full sector, on a lock command, or when loads stop for a while.
    always begin
        #50;
        if (go || (ld.num() > 0 && $time - t_last > 1000)) begin
            go = 1'b0;
            busy = 1'b1;
            for (int i = 0; i < 256 && ld.num() > 0; i++) begin
                a = {sect, 8'(i)};
                if (!(lk_lo && a < 19'h04000) && !(lk_hi && a >= 19'h7C000))
                    mem[a] = ld.exists(i) ? ld[i] : 8'hXX;
            end
            ld.delete();
            #3000;
            busy = 1'b0;
            if (pp) prot = 1'b1;
            if (pu) prot = 1'b0;
            pp = 1'b0;
            pu = 1'b0;
        end
    end
    // Each read strobe while busy flips the status bit; its level carries no meaning.
    always @(negedge rd_n) if (busy) tog = ~tog;
    assign o_dq = rd_n ? flt : busy ? {1'b0, tog, 6'h00} :
                  !id ? mem[i_addr] : i_addr == 19'h0 ? MAN_ID : i_addr == 19'h1 ? DEV_ID :
                  i_addr == 19'h2 ? {7'h7F, lk_lo} : i_addr == 19'h7FFF2 ? {7'h7F, lk_hi} : 8'hFF;
endmodule : flash_part_model
`default_nettype wire

// ===== testbench/test_flash_sector_host.sv
`timescale 1ns/1ps
`default_nettype none
// Host controller against the part model, one task per scenario.
module test_flash_sector_host;
    logic clk = 0, rst = 1, cv = 0, wv = 0, ack, busy, done, err, idm, ce_n, oe_n, we_n, dq_oe;
    logic [2:0]  op = '0;
    logic [18:0] ca = '0, fa;
    logic [7:0]  wd = '0, rd, dq_o, dq_m;
    wire  [7:0]  dq = dq_oe ? dq_o : dq_m; // Whoever enables drives the pins.
    int error_cnt = 0, num_checks = 0, cyc = 0;
    always #5 clk = ~clk;
    flash_sector_host #(.BLC_CYCLES(200), .POLL_LIMIT(500)) dut (.I_SYS_CLK(clk), .I_RESET(rst),
        .i_CMD_VALID(cv), .i_CMD_OP(op), .i_CMD_ADDR(ca), .i_WR_VALID(wv), .i_WR_DATA(wd), .o_WR_ACK(ack),
        .o_BUSY(busy), .o_DONE(done), .o_ERR(err), .o_RD_DATA(rd), .o_ID_MODE(idm), .o_FLASH_ADDR(fa),
        .o_FLASH_CE_N(ce_n), .o_FLASH_OE_N(oe_n), .o_FLASH_WE_N(we_n), .i_FLASH_DQ(dq), .o_FLASH_DQ(dq_o),
        .o_FLASH_DQ_OE(dq_oe));
    flash_part_model m (.i_addr(fa), .i_ce_n(ce_n), .i_oe_n(oe_n), .i_we_n(we_n), .i_dq(dq), .o_dq(dq_m));
    task automatic conclude;
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : conclude
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // One request, then bytes offset by offset until done; valid moves only in the ack cycle.
    task automatic cmd(input logic [2:0] o, input logic [18:0] a, input int nb);
        int n;
        n = 0;
        @(negedge clk); cv = 1; op = o; ca = a;
        @(negedge clk); cv = 0; wv = (nb > 0); wd = 8'h5A;
        chk({7'h0, busy}, 8'h01);
        for (int w = 0; w < 20000 && done !== 1'b1; w++) begin
            @(negedge clk);
            if (ack === 1'b1) n++;
            wv = (n < nb);
            wd = 8'(n) ^ 8'h5A;
        end
        chk({6'h0, busy, done}, 8'h01);
    endtask : cmd
    task automatic t_id;
        cmd(4, 0, 0); chk({7'h0, idm}, 8'h01);
        cmd(0, 0, 0); chk(rd, 8'h3C);
        cmd(0, 1, 0); chk(rd, 8'h7E);
        cmd(0, 2, 0); chk(rd, 8'hFE);
        cmd(0, 19'h7FFF2, 0); chk(rd, 8'hFE);
        cmd(5, 0, 0); chk({7'h0, idm}, 8'h00);
        cmd(0, 0, 0); chk(rd, 8'hFF);
        $display("test id done");
    endtask : t_id
    task automatic t_prog;
        cmd(1, 19'h12300, 256); chk({7'h0, err}, 8'h00);
        for (int k = 0; k < 256; k += 127) begin
            cmd(0, 19'h12300 | 19'(k), 0); chk(rd, 8'(k) ^ 8'h5A);
        end
        $display("test program done");
    endtask : t_prog
    task automatic t_prot;
        cmd(2, 19'h00400, 256); chk({7'h0, m.prot}, 8'h01);
        cmd(3, 19'h00500, 256); chk({7'h0, m.prot}, 8'h00);
        $display("test protect done");
    endtask : t_prot
    task automatic t_late;
        cmd(1, 19'h20000, 10); chk({7'h0, err}, 8'h01);
        cmd(0, 19'h20009, 0); chk(rd, 8'h53);
        chk({7'h0, err}, 8'h00);
        $display("test timeout done");
    endtask : t_late
    task automatic t_lock;
        cmd(6, 0, 0); cmd(7, 0, 0); chk({7'h0, err}, 8'h00);
        cmd(4, 0, 0); cmd(0, 2, 0); chk(rd, 8'hFF);
        cmd(0, 19'h7FFF2, 0); chk(rd, 8'hFF);
        cmd(5, 0, 0); cmd(1, 0, 256); cmd(0, 19'h00010, 0); chk(rd, 8'hFF);
        $display("test lockout done");
    endtask : t_lock
    initial begin
        repeat (12) @(negedge clk);
        rst = 0;
        t_id();
        t_prog();
        t_prot();
        t_late();
        t_lock();
        conclude();
    end
    // A hang counts as a mismatch and still ends in the verdict.
    always @(posedge clk) begin
        cyc++;
        if (cyc == 90000) begin
            error_cnt++;
            conclude();
        end
    end
endmodule : test_flash_sector_host
`default_nettype wire
